// File: shared/uart_ctrl_pkg.sv
// Behaviour
// - transmit and receive hardware flow control are enabled by two separate bits, any combination allowed.
// - with transmit flow control on, a new character may start only while cts is asserted.
// - with receive flow control on, rts is driven by hardware, asserted only while the receive fifo has room.
// - twelve maskable interrupt sources: addr match, overrun, break, parity, framing, timeout, tx, rx, dsr, dcd, cts, ri.
// - each source has an enable bit and only enabled sources reach the interrupt output.
// - software can read the raw status and the masked status of all sources.
// - a set source stays pending until cleared, and clearing some sources leaves the others alone.
// - software sets dtr and rts individually through a bit mask, unselected outputs unchanged.
// - software clears dtr and rts individually through a bit mask.
// - the present state of dtr and rts is readable as one flag each.
// - the present state of ri, dcd, dsr and cts is readable as one flag each.
// - tx and rx interrupts fire at a programmable fifo threshold of 1, 2, 4, 6 or 7 eighths.
// - in end-of-transmission mode the tx interrupt needs an empty fifo and an idle transmitter, else it is level based.
package uart_ctrl_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] FLOW_CTRL_OFS   = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_OFS  = 8'h04;
   localparam logic [7:0] IRQ_RAW_OFS     = 8'h08;
   localparam logic [7:0] IRQ_MASKED_OFS  = 8'h0C;
   localparam logic [7:0] IRQ_CLEAR_OFS   = 8'h10;
   localparam logic [7:0] MODEM_SET_OFS   = 8'h14;
   localparam logic [7:0] MODEM_CLR_OFS   = 8'h18;
   localparam logic [7:0] MODEM_OUT_OFS   = 8'h1C;
   localparam logic [7:0] MODEM_IN_OFS    = 8'h20;
   localparam logic [7:0] FIFO_LEVEL_OFS  = 8'h24;
   localparam logic [7:0] TX_MODE_OFS     = 8'h28;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int TX_GATE_BIT  = 0;   // flow ctrl: tx_handshake_gate_enable
   localparam int RX_AUTO_BIT  = 1;   // flow ctrl: rx_handshake_auto_enable
   localparam int DTR_BIT      = 0;   // modem out
   localparam int RTS_BIT      = 1;
   localparam int RI_BIT       = 0;   // modem in
   localparam int DCD_BIT      = 1;
   localparam int DSR_BIT      = 2;
   localparam int CTS_BIT      = 3;
   localparam int IRQ_ADDR     = 0;
   localparam int IRQ_OVERRUN  = 1;
   localparam int IRQ_BREAK    = 2;
   localparam int IRQ_PARITY   = 3;
   localparam int IRQ_FRAMING  = 4;
   localparam int IRQ_TIMEOUT  = 5;
   localparam int IRQ_TX       = 6;
   localparam int IRQ_RX       = 7;
   localparam int IRQ_DSR      = 8;
   localparam int IRQ_DCD      = 9;
   localparam int IRQ_CTS      = 10;
   localparam int IRQ_RI       = 11;
   localparam int IRQ_COUNT    = 12;
   localparam int RX_LVL_LSB   = 4;   // fifo level reg: tx sel [2:0], rx sel [6:4]
   // ------------------------------------------------------------
   // reset values and threshold codes
   // ------------------------------------------------------------
   localparam logic [1:0]  FLOW_RESET   = 2'h0;  // handshake_off
   localparam logic [11:0] IRQ_RESET    = 12'h000;
   localparam logic [1:0]  MODEM_RESET  = 2'h0;
   localparam logic [2:0]  LVL_RESET    = 3'h2;  // four eighths
   localparam logic [2:0]  LVL_1_8      = 3'h0;
   localparam logic [2:0]  LVL_2_8      = 3'h1;
   localparam logic [2:0]  LVL_4_8      = 3'h2;
   localparam logic [2:0]  LVL_6_8      = 3'h3;
   localparam logic [2:0]  LVL_7_8      = 3'h4;
   localparam logic        TX_IRQ_ON_LEVEL = 1'b0;
   localparam logic        TX_IRQ_ON_IDLE  = 1'b1;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
endpackage

// File: src/level_thresh.sv
`timescale 1ns/1ps
// fifo fill compare against a selectable eighth of the depth
module level_thresh
   import uart_ctrl_pkg::*;
#(
   parameter int DEPTH_W = 5
) (
   input  wire logic [2:0]       sel,
   input  wire logic [DEPTH_W:0] fill,
   output logic                  reached
);
   localparam int DEPTH = 1 << DEPTH_W;

   // ------------------------------------------------------------
   // threshold in entries
   // ------------------------------------------------------------
   // unknown codes fall back to half, the reset choice
   wire [DEPTH_W+3:0] depth_w = (DEPTH_W+4)'(DEPTH);
   wire [DEPTH_W+3:0] eighths = (sel == LVL_1_8) ? (DEPTH_W+4)'(1) :
                                (sel == LVL_2_8) ? (DEPTH_W+4)'(2) :
                                (sel == LVL_6_8) ? (DEPTH_W+4)'(6) :
                                (sel == LVL_7_8) ? (DEPTH_W+4)'(7) : (DEPTH_W+4)'(4);
   wire [DEPTH_W+6:0] prod    = (DEPTH_W+7)'(depth_w) * (DEPTH_W+7)'(eighths);
   wire [DEPTH_W+6:0] fill_x  = (DEPTH_W+7)'(fill);
   assign reached = (fill_x << 3) >= prod;
endmodule

// File: src/uart_flow_modem_irq_ctrl.sv
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module uart_flow_modem_irq_ctrl
   import uart_ctrl_pkg::*;
#(
   parameter int DEPTH_W = 5
) (
   input  wire logic               hclk,
   input  wire logic               hresetn,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic [31:0]             hrdata,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic                    irq,
   input  wire logic               cts_n_pin,
   input  wire logic               dsr_n_pin,
   input  wire logic               dcd_n_pin,
   input  wire logic               ri_n_pin,
   output logic                    rts_n_pin,
   output logic                    dtr_n_pin,
   input  wire logic [DEPTH_W:0]   rx_fill,
   input  wire logic [DEPTH_W:0]   tx_fill,
   input  wire logic               tx_busy,
   input  wire logic               tx_char_ready,
   output logic                    tx_start_ok,
   input  wire logic               addr_match_evt,
   input  wire logic               overrun_evt,
   input  wire logic               break_evt,
   input  wire logic               parity_fail_evt,
   input  wire logic               framing_fail_evt,
   input  wire logic               rx_idle_timeout_evt
);
   localparam int DEPTH = 1 << DEPTH_W;

   // ------------------------------------------------------------
   // bus address phase capture
   // ------------------------------------------------------------
   logic        wr_q, rd_q;
   logic [7:0]  addr_q;
   wire         take = hsel && hready && htrans == HTRANS_NONSEQ;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_q   <= take && hwrite;
         rd_q   <= take && !hwrite;
         addr_q <= take ? haddr[7:0] : addr_q;
      end
   end
   // zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   wire wr_flow  = wr_q && addr_q == FLOW_CTRL_OFS;
   wire wr_en    = wr_q && addr_q == IRQ_ENABLE_OFS;
   wire wr_clr   = wr_q && addr_q == IRQ_CLEAR_OFS;
   wire wr_mset  = wr_q && addr_q == MODEM_SET_OFS;
   wire wr_mclr  = wr_q && addr_q == MODEM_CLR_OFS;
   wire wr_lvl   = wr_q && addr_q == FIFO_LEVEL_OFS;
   wire wr_txm   = wr_q && addr_q == TX_MODE_OFS;

   // ------------------------------------------------------------
   // modem input synchronisers
   // ------------------------------------------------------------
   // pins are active low; flags read as one when asserted
   logic [3:0] in_meta_q, in_sync_q, in_prev_q;
   wire  [3:0] in_pins = {~cts_n_pin, ~dsr_n_pin, ~dcd_n_pin, ~ri_n_pin};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_meta_q <= 4'h0;
         in_sync_q <= 4'h0;
         in_prev_q <= 4'h0;
      end else begin
         in_meta_q <= in_pins;
         in_sync_q <= in_meta_q;
         in_prev_q <= in_sync_q;
      end
   end
   wire [3:0] in_change = in_sync_q ^ in_prev_q;

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   logic [1:0]           flow_q;
   logic [IRQ_COUNT-1:0] en_q;
   logic [1:0]           mout_q;
   logic [2:0]           tx_lvl_q, rx_lvl_q;
   logic                 tx_mode_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flow_q    <= FLOW_RESET;
         en_q      <= IRQ_RESET;
         tx_lvl_q  <= LVL_RESET;
         rx_lvl_q  <= LVL_RESET;
         tx_mode_q <= TX_IRQ_ON_LEVEL;
      end else begin
         if (wr_flow) flow_q <= hwdata[1:0];
         if (wr_en)   en_q <= hwdata[IRQ_COUNT-1:0];
         if (wr_lvl) begin
            tx_lvl_q <= hwdata[2:0];
            rx_lvl_q <= hwdata[RX_LVL_LSB+2:RX_LVL_LSB];
         end
         if (wr_txm)  tx_mode_q <= hwdata[0];
      end
   end

   // set then clear by mask; a set and clear in one write is not possible
   wire [1:0] mout_d = (mout_q | (wr_mset ? hwdata[1:0] : 2'h0))
                       & ~(wr_mclr ? hwdata[1:0] : 2'h0);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) mout_q <= MODEM_RESET;
      else          mout_q <= mout_d;
   end

   // ------------------------------------------------------------
   // flow control
   // ------------------------------------------------------------
   wire tx_gate_on  = flow_q[TX_GATE_BIT];
   wire rx_auto_on  = flow_q[RX_AUTO_BIT];
   wire rx_has_room = rx_fill < (DEPTH_W+1)'(DEPTH);
   // rts from hardware in auto mode, else the software bit
   wire rts_level   = rx_auto_on ? rx_has_room : mout_q[RTS_BIT];
   // only the start is gated; a character in flight finishes
   assign tx_start_ok = !tx_gate_on || in_sync_q[CTS_BIT];

   logic rts_q, dtr_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rts_q <= 1'b0;
         dtr_q <= 1'b0;
      end else begin
         rts_q <= rts_level;
         dtr_q <= mout_q[DTR_BIT];
      end
   end
   assign rts_n_pin = ~rts_q;
   assign dtr_n_pin = ~dtr_q;

   // ------------------------------------------------------------
   // fifo level and end-of-transmission events
   // ------------------------------------------------------------
   logic tx_above, rx_above;
   // compare one less than the fill, so reaching means strictly above the threshold
   wire [DEPTH_W:0] tx_fill_m1 = tx_fill - (DEPTH_W+1)'(1);
   level_thresh #(.DEPTH_W(DEPTH_W)) tx_cmp (
      .sel     (tx_lvl_q),
      .fill    (tx_fill_m1),
      .reached (tx_above)
   );
   level_thresh #(.DEPTH_W(DEPTH_W)) rx_cmp (
      .sel     (rx_lvl_q),
      .fill    (rx_fill),
      .reached (rx_above)
   );
   // tx fires while at or below its threshold, rx at or above
   // an empty fifo wraps the minus one, so it is caught on its own
   wire tx_at_lvl  = !tx_above || tx_fill == '0;
   wire tx_idle    = tx_fill == '0 && !tx_busy;
   wire tx_cond    = (tx_mode_q == TX_IRQ_ON_IDLE) ? tx_idle : tx_at_lvl;
   logic tx_cond_q, rx_cond_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_cond_q <= 1'b0;
         rx_cond_q <= 1'b0;
      end else begin
         tx_cond_q <= tx_cond;
         rx_cond_q <= rx_above;
      end
   end
   // edge into the condition raises the sticky bit
   wire tx_evt = tx_cond && !tx_cond_q;
   wire rx_evt = rx_above && !rx_cond_q;

   // ------------------------------------------------------------
   // interrupt status
   // ------------------------------------------------------------
   wire [IRQ_COUNT-1:0] evt = {in_change[RI_BIT], in_change[CTS_BIT], in_change[DCD_BIT],
                               in_change[DSR_BIT], rx_evt, tx_evt, rx_idle_timeout_evt,
                               framing_fail_evt, parity_fail_evt, break_evt, overrun_evt,
                               addr_match_evt};
   logic [IRQ_COUNT-1:0] raw_q;
   wire  [IRQ_COUNT-1:0] clr_mask = wr_clr ? hwdata[IRQ_COUNT-1:0] : '0;
   // set beats clear so a coincident event survives
   wire  [IRQ_COUNT-1:0] raw_d    = (raw_q & ~clr_mask) | evt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) raw_q <= IRQ_RESET;
      else          raw_q <= raw_d;
   end
   wire [IRQ_COUNT-1:0] masked = raw_q & en_q;
   // level output: software must clear early in the handler
   assign irq = |masked;

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   wire [31:0] rd_mux =
      (addr_q == FLOW_CTRL_OFS)  ? {30'h0, flow_q} :
      (addr_q == IRQ_ENABLE_OFS) ? {20'h0, en_q} :
      (addr_q == IRQ_RAW_OFS)    ? {20'h0, raw_q} :
      (addr_q == IRQ_MASKED_OFS) ? {20'h0, masked} :
      (addr_q == MODEM_OUT_OFS)  ? {30'h0, rts_q, dtr_q} :
      (addr_q == MODEM_IN_OFS)   ? {28'h0, in_sync_q} :
      (addr_q == FIFO_LEVEL_OFS) ? {25'h0, rx_lvl_q, 1'b0, tx_lvl_q} :
      (addr_q == TX_MODE_OFS)    ? {31'h0, tx_mode_q} : 32'h0000_0000;
   assign hrdata = rd_q ? rd_mux : 32'h0000_0000;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   irq_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
      raw_q[IRQ_BREAK] && !(wr_clr && hwdata[IRQ_BREAK]) |=> raw_q[IRQ_BREAK])
      else $error("pending source dropped without clear");
   irq_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_clr && hwdata[IRQ_PARITY] && !parity_fail_evt |=> !raw_q[IRQ_PARITY])
      else $error("clear did not reset source");
   irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      en_q == '0 |-> !irq)
      else $error("irq not gated by enables");
   irq_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
      overrun_evt |=> raw_q[IRQ_OVERRUN])
      else $error("event not captured");
   tx_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_gate_on && !in_sync_q[CTS_BIT] |-> !tx_start_ok)
      else $error("start allowed without cts");
   rts_auto_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rx_auto_on && rx_fill == (DEPTH_W+1)'(DEPTH) ##1 rx_auto_on |-> rts_n_pin)
      else $error("rts asserted with full fifo");
   modem_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_mset && hwdata[DTR_BIT] |=> ##1 !dtr_n_pin)
      else $error("dtr not asserted by set");
   modem_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_mclr && hwdata[DTR_BIT] && !wr_mset |=> ##1 dtr_n_pin)
      else $error("dtr not cleared");
   cts_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !cts_n_pin [*3] |-> in_sync_q[CTS_BIT])
      else $error("cts flag stale");
   eot_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
      tx_mode_q == TX_IRQ_ON_IDLE && tx_busy |-> !tx_evt)
      else $error("tx irq while busy in eot mode");
endmodule

// File: sim/modem_far_end.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// remote terminal on the handshake lines
// ------------------------------------------------------------
module modem_far_end
   import uart_ctrl_pkg::*;
(
   input  wire logic       rts_n_pin,
   input  wire logic       dtr_n_pin,
   input  wire logic [3:0] lines_on,
   output logic            cts_n_pin,
   output logic            dsr_n_pin,
   output logic            dcd_n_pin,
   output logic            ri_n_pin,
   output logic            peer_may_send
);
   // an asserted line is pulled low on the wire
   assign cts_n_pin = ~lines_on[CTS_BIT];
   assign dsr_n_pin = ~lines_on[DSR_BIT];
   assign dcd_n_pin = ~lines_on[DCD_BIT];
   assign ri_n_pin  = ~lines_on[RI_BIT];
   // the terminal sends only while both our handshake outputs are asserted
   assign peer_may_send = ~rts_n_pin & ~dtr_n_pin;
endmodule

// File: sim/uart_flow_modem_irq_ctrl_tb_top.sv
`timescale 1ns/1ps
module uart_flow_modem_irq_ctrl_tb_top;
   import uart_ctrl_pkg::*;
   localparam int DW = 5;
   logic          hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tx_busy = 1'b0;
   logic [31:0]   haddr = '0, hwdata = '0, rd, hrdata;
   logic [1:0]    htrans = 2'h0;
   logic [2:0]    hsize = 3'h2;
   logic [5:0]    evt_q = '0;
   logic [3:0]    lines_q = '0;
   logic [DW:0]   rx_fill = '0, tx_fill = '0;
   logic          hreadyout, hresp, irq, rts_n_pin, dtr_n_pin, tx_start_ok, peer_may_send;
   logic          cts_n_pin, dsr_n_pin, dcd_n_pin, ri_n_pin;
   int            fail_count = 0, samples_checked = 0;
   int            eighths [5] = '{1, 2, 4, 6, 7};
   int            thr;

   uart_flow_modem_irq_ctrl #(.DEPTH_W(DW)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
      .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin), .dcd_n_pin(dcd_n_pin), .ri_n_pin(ri_n_pin),
      .rts_n_pin(rts_n_pin), .dtr_n_pin(dtr_n_pin), .rx_fill(rx_fill), .tx_fill(tx_fill),
      .tx_busy(tx_busy), .tx_char_ready(1'b0), .tx_start_ok(tx_start_ok),
      .addr_match_evt(evt_q[IRQ_ADDR]), .overrun_evt(evt_q[IRQ_OVERRUN]), .break_evt(evt_q[IRQ_BREAK]),
      .parity_fail_evt(evt_q[IRQ_PARITY]), .framing_fail_evt(evt_q[IRQ_FRAMING]),
      .rx_idle_timeout_evt(evt_q[IRQ_TIMEOUT]));
   modem_far_end peer (.rts_n_pin(rts_n_pin), .dtr_n_pin(dtr_n_pin), .lines_on(lines_q),
      .cts_n_pin(cts_n_pin), .dsr_n_pin(dsr_n_pin), .dcd_n_pin(dcd_n_pin), .ri_n_pin(ri_n_pin),
      .peer_may_send(peer_may_send));

   // ------------------------------------------------------------
   // bus and compare helpers
   // ------------------------------------------------------------
   initial forever #12.5 hclk = ~hclk;
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // single transfer; address held until hready, read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
      hsel <= 1'b1; haddr <= {24'h0, ofs}; htrans <= HTRANS_NONSEQ; hwrite <= wr; hsize <= 3'h2;
      @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0; hsel <= 1'b0; hwdata <= wd;
      @(posedge hclk); while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
      ahb(1'b1, ofs, d);
   endtask
   task automatic rdchk(input logic [7:0] ofs, input logic [31:0] m, input logic [31:0] exp);
      ahb(1'b0, ofs, 32'h0);
      chk(rd & m, exp);
   endtask
   task report_and_stop;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rdchk(FLOW_CTRL_OFS, '1, {30'h0, FLOW_RESET});
      rdchk(IRQ_ENABLE_OFS, '1, {20'h0, IRQ_RESET});
      rdchk(FIFO_LEVEL_OFS, '1, {25'h0, LVL_RESET, 1'b0, LVL_RESET});
      rdchk(MODEM_OUT_OFS, '1, 32'h0);
      rdchk(8'h3C, '1, 32'h0);
      chk({30'h0, hresp, hreadyout}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_events;
      for (int i = 0; i < 6; i++) begin
         wr(IRQ_CLEAR_OFS, 32'hFFF);
         evt_q <= 6'(1 << i);
         tick(1);
         evt_q <= '0;
         rdchk(IRQ_RAW_OFS, 32'h3F, 32'(1 << i));
      end
      wr(IRQ_ENABLE_OFS, 32'(1 << IRQ_OVERRUN));
      evt_q <= 6'h0A;
      tick(1);
      evt_q <= '0;
      rdchk(IRQ_MASKED_OFS, '1, 32'(1 << IRQ_OVERRUN));
      chk({31'h0, irq}, 32'h1);
      wr(IRQ_CLEAR_OFS, 32'(1 << IRQ_OVERRUN));
      rdchk(IRQ_RAW_OFS, 32'h3F, 32'((1 << IRQ_PARITY) | (1 << IRQ_TIMEOUT)));
      chk({31'h0, irq}, 32'h0);
      $display("test events done");
   endtask
   task automatic t_modem;
      wr(MODEM_SET_OFS, 32'(1 << DTR_BIT));
      rdchk(MODEM_OUT_OFS, '1, 32'h1);
      chk({30'h0, rts_n_pin, dtr_n_pin}, 32'h2);
      wr(MODEM_SET_OFS, 32'(1 << RTS_BIT));
      rdchk(MODEM_OUT_OFS, '1, 32'h3);
      chk({31'h0, peer_may_send}, 32'h1);
      wr(MODEM_CLR_OFS, 32'(1 << DTR_BIT));
      rdchk(MODEM_OUT_OFS, '1, 32'h2);
      chk({30'h0, rts_n_pin, dtr_n_pin}, 32'h1);
      $display("test modem out done");
   endtask
   // two sync flops plus the change detector need a few cycles
   task automatic t_inputs;
      wr(IRQ_CLEAR_OFS, 32'hFFF);
      for (int i = 0; i < 4; i++) begin
         lines_q <= 4'(1 << i);
         tick(4);
         rdchk(MODEM_IN_OFS, '1, 32'(1 << i));
         lines_q <= '0;
         tick(4);
      end
      rdchk(IRQ_RAW_OFS, 32'hF00, 32'hF00);
      $display("test modem in done");
   endtask
   task automatic t_flow;
      wr(MODEM_CLR_OFS, 32'h3);
      tick(4);
      chk({31'h0, tx_start_ok}, 32'h1);
      wr(FLOW_CTRL_OFS, 32'h1);
      tick(1);
      chk({31'h0, tx_start_ok}, 32'h0);
      lines_q <= 4'(1 << CTS_BIT);
      tick(4);
      chk({31'h0, tx_start_ok}, 32'h1);
      wr(FLOW_CTRL_OFS, 32'h3);
      rx_fill <= 6'd32;
      tick(3);
      chk({31'h0, rts_n_pin}, 32'h1);
      rx_fill <= 6'd31;
      tick(3);
      chk({31'h0, rts_n_pin}, 32'h0);
      wr(FLOW_CTRL_OFS, 32'h2);
      lines_q <= '0;
      tick(4);
      chk({30'h0, tx_start_ok, rts_n_pin}, 32'h2);
      wr(FLOW_CTRL_OFS, 32'h0);
      rx_fill <= '0;
      $display("test flow done");
   endtask
   task automatic t_level;
      for (int c = 0; c < 5; c++) begin
         thr = (1 << DW) * eighths[c] / 8;
         wr(FIFO_LEVEL_OFS, 32'((c << RX_LVL_LSB) | c));
         tx_fill <= 6'(thr + 1);
         wr(IRQ_CLEAR_OFS, 32'((1 << IRQ_RX) | (1 << IRQ_TX)));
         rx_fill <= 6'(thr - 1);
         tick(2);
         rdchk(IRQ_RAW_OFS, 32'hC0, 32'h0);
         rx_fill <= 6'(thr);
         tx_fill <= 6'(thr);
         tick(2);
         rdchk(IRQ_RAW_OFS, 32'hC0, 32'hC0);
         rx_fill <= '0;
         tx_fill <= '0;
      end
      $display("test level done");
   endtask
   task automatic t_eot;
      wr(TX_MODE_OFS, {31'h0, TX_IRQ_ON_IDLE});
      tx_fill <= 6'd3;
      tx_busy <= 1'b1;
      tick(2);
      wr(IRQ_CLEAR_OFS, 32'(1 << IRQ_TX));
      tx_fill <= '0;
      tick(2);
      rdchk(IRQ_RAW_OFS, 32'h40, 32'h0);
      tx_busy <= 1'b0;
      tick(2);
      rdchk(IRQ_RAW_OFS, 32'h40, 32'h40);
      $display("test eot done");
   endtask

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #(25 * 20000);
      fail_count++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_events;
      t_modem;
      t_inputs;
      t_flow;
      t_level;
      t_eot;
      report_and_stop;
   end
endmodule
